// ### core/rcwr_map.svh
// Constants for the remote command word receiver: timing counts and fields
`ifndef RCWR_MAP_SVH
`define RCWR_MAP_SVH
`define RCWR_CLK_HZ 100000000
`define RCWR_REF_HZ 500000
`define RCWR_REF_DIV (`RCWR_CLK_HZ / `RCWR_REF_HZ)
`define RCWR_EOT_MS 550
`define RCWR_EOT_TICKS ((`RCWR_EOT_MS * `RCWR_REF_HZ) / 1000)
`define RCWR_WORD_BITS 12
`define RCWR_ADDR_POS 11
`define RCWR_CMD_LSB 0
`define RCWR_CMD_W 6
`define RCWR_PAR_POS 6
`define RCWR_EOT_CODE 6'h3f
`define RCWR_SUB_LO 6'h38
`define RCWR_SUB_HI 6'h3e
`define RCWR_SUB_OFF0 6'h02
`define RCWR_SUB_OFF1 6'h0c
`define RCWR_SUB_OFF2 6'h3f
`define RCWR_WIN_TOL 4
`define RCWR_MIN_GAP 8
`define RCWR_SER_DIV 8
`define RCWR_FIFO_DEPTH 16
`endif

// ### core/rcwr_pkg.sv
// Types shared by the remote command word receiver
package rcwr_pkg;
    typedef struct packed {
        logic       eot;
        logic [5:0] cmd;
    } rcwr_word_t;
    typedef enum logic [2:0] {
        RX_IDLE, RX_SYNC, RX_BITS, RX_QUIET, RX_DONE
    } rcwr_rx_state_t;
    typedef enum logic [1:0] {
        SER_IDLE, SER_SHIFT, SER_STROBE
    } rcwr_ser_state_t;
endpackage

// ### core/rcwr_fifo.sv
// Parameterised valid/ready FIFO between decoder and serialiser
`timescale 1ns/1ps
`include "rcwr_map.svh"
module rcwr_fifo #(
    parameter int WIDTH = 7,
    parameter int DEPTH = 16
)
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Storage write
    always_ff @(posedge clock)
    begin
        if (push)
            mem_q[wr_q] <= in_data;
    end

    // Pointers and fill count
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
                wr_q <= wr_q + AW'(1);
            if (pop)
                rd_q <= rd_q + AW'(1);
            if (push && !pop)
                cnt_q <= cnt_q + (AW+1)'(1);
            else if (pop && !push)
                cnt_q <= cnt_q - (AW+1)'(1);
        end
    end
endmodule

// ### core/rcwr_top.sv
// Remote command word receiver: pulse checks, decode, serial output
//
// Behaviour
// - Accept words only when address field matches the selected address.
// - In subsystem mode, repeated command sends once until end of transmission.
// - Work from any 445-510 kHz reference; no lock to transmitter.
// - Measure pulse spacing to set the bit time base per word.
// - Every bit pulse must land inside its window, else drop word.
// - Check parity bit; mismatch fails the word.
// - No pulse allowed between the last command bit and stop pulse.
// - Spurious pulses inside or outside windows fail the word.
// - Failed words are discarded, never decoded or forwarded.
// - Valid word is latched, decoded and sent on the serial bus.
// - End of transmission on received code or after about 550 ms silence.
// - Declared end of transmission is also sent on the serial bus.
// - Address select low picks address 1, high picks address 2.
// - Commands 56-62 enter subsystem mode; 2, 12, 63 leave; off at reset.
`timescale 1ns/1ps
`include "rcwr_map.svh"
module rcwr_top #(
    parameter int EOT_TICKS = `RCWR_EOT_TICKS,
    parameter int REF_DIV = `RCWR_REF_DIV,
    parameter bit SER_MSB_FIRST = 1'b1
)
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic pulse_in,
    input wire logic addr_sel,
    output logic ser_data_o,
    output logic ser_data_oe,
    output logic ser_clk_o,
    output logic ser_clk_oe,
    output logic ser_strobe_o,
    output logic ser_strobe_oe,
    output logic subsys_n,
    output logic [5:0] cmd_out,
    output logic cmd_valid
);
    // ------------------------------------------------------------
    // Reset release and reference tick
    // ------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic rst_n;
    logic [15:0] div_q;
    logic tick;

    // Two-stage reset release
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            rst_sync_q <= 2'h0;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    // Reference-rate enable, same role as the free-running oscillator
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            div_q <= 16'h0;
        else if (div_q == 16'(REF_DIV - 1))
            div_q <= 16'h0;
        else
            div_q <= div_q + 16'h1;
    end
    assign tick = (div_q == 16'(REF_DIV - 1));

    // ------------------------------------------------------------
    // Pulse capture and word checker
    // ------------------------------------------------------------
    logic pin_q;
    logic pulse_edge;
    logic tick_pulse_q;
    rcwr_pkg::rcwr_rx_state_t st_q;
    logic [11:0] since_q;
    logic [11:0] base_q;
    logic [3:0] nbit_q;
    logic [11:0] shreg_q;
    logic word_ok;
    logic word_bad;

    // Rising edge of the preamplified pulse line, held until next tick
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_q <= 1'b0;
            tick_pulse_q <= 1'b0;
        end
        else
        begin
            pin_q <= pulse_in;
            if (tick)
                tick_pulse_q <= pulse_edge;
            else if (pulse_edge)
                tick_pulse_q <= 1'b1;
        end
    end
    assign pulse_edge = pulse_in && !pin_q;

    // Spacing to bit value: short gap is 0, one and a half base is 1
    function automatic logic [1:0] classify(input logic [11:0] gap,
                                            input logic [11:0] base);
        logic [11:0] one_t;
        one_t = base + (base >> 1);
        if (gap + 12'(`RCWR_WIN_TOL) >= base
            && gap <= base + 12'(`RCWR_WIN_TOL))
            classify = 2'h1;
        else if (gap + 12'(`RCWR_WIN_TOL) >= one_t
                 && gap <= one_t + 12'(`RCWR_WIN_TOL))
            classify = 2'h2;
        else
            classify = 2'h0;
    endfunction

    logic [1:0] cls;
    assign cls = classify(since_q, base_q);

    // Word state machine on reference ticks
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q <= rcwr_pkg::RX_IDLE;
            since_q <= 12'h0;
            base_q <= 12'h0;
            nbit_q <= 4'h0;
            shreg_q <= 12'h0;
        end
        else if (tick)
        begin
            if (since_q != 12'hfff)
                since_q <= since_q + 12'h1;
            case (st_q)
                rcwr_pkg::RX_IDLE:
                begin
                    if (tick_pulse_q)
                    begin
                        st_q <= rcwr_pkg::RX_SYNC;
                        since_q <= 12'h0;
                    end
                end
                rcwr_pkg::RX_SYNC:
                begin
                    if (tick_pulse_q)
                    begin
                        // Reference gap sets the base, no transmitter lock
                        if (since_q >= 12'(`RCWR_MIN_GAP))
                        begin
                            base_q <= since_q;
                            st_q <= rcwr_pkg::RX_BITS;
                            nbit_q <= 4'h0;
                        end
                        else
                            st_q <= rcwr_pkg::RX_IDLE;
                        since_q <= 12'h0;
                    end
                    else if (since_q == 12'hfff)
                        st_q <= rcwr_pkg::RX_IDLE;
                end
                rcwr_pkg::RX_BITS:
                begin
                    if (tick_pulse_q)
                    begin
                        if (cls == 2'h0)
                            st_q <= rcwr_pkg::RX_IDLE;
                        else
                        begin
                            shreg_q <= {shreg_q[10:0], cls[1]};
                            nbit_q <= nbit_q + 4'h1;
                            if (nbit_q == 4'(`RCWR_WORD_BITS - 1))
                                st_q <= rcwr_pkg::RX_QUIET;
                        end
                        since_q <= 12'h0;
                    end
                    else if (since_q > (base_q << 1))
                        st_q <= rcwr_pkg::RX_IDLE;
                end
                rcwr_pkg::RX_QUIET:
                begin
                    // Stop pulse must come at twice base with nothing before
                    if (tick_pulse_q)
                    begin
                        if (since_q + 12'(`RCWR_WIN_TOL) >= (base_q << 1))
                            st_q <= rcwr_pkg::RX_DONE;
                        else
                            st_q <= rcwr_pkg::RX_IDLE;
                        since_q <= 12'h0;
                    end
                    else if (since_q > (base_q << 1) + 12'(`RCWR_WIN_TOL))
                        st_q <= rcwr_pkg::RX_IDLE;
                end
                rcwr_pkg::RX_DONE:
                    st_q <= rcwr_pkg::RX_IDLE;
                default:
                    st_q <= rcwr_pkg::RX_IDLE;
            endcase
        end
    end

    // Parity over the command bits against the parity bit
    logic par_ok;
    logic addr_ok;
    assign par_ok = (^shreg_q[5:0]) == shreg_q[`RCWR_PAR_POS];
    assign addr_ok = shreg_q[`RCWR_ADDR_POS] == addr_sel;
    assign word_ok = tick && st_q == rcwr_pkg::RX_DONE && par_ok && addr_ok;
    assign word_bad = tick && st_q == rcwr_pkg::RX_DONE && !word_ok;

    // ------------------------------------------------------------
    // Decode, subsystem mode, end of transmission
    // ------------------------------------------------------------
    logic [5:0] rx_cmd;
    logic [19:0] eot_cnt_q;
    logic active_q;
    logic eot_evt;
    logic sent_q;
    logic push_valid;
    rcwr_pkg::rcwr_word_t push_word;
    logic push_ready;
    assign rx_cmd = shreg_q[`RCWR_CMD_LSB +: `RCWR_CMD_W];

    // Silence timer restarted by each valid word other than the end code
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            eot_cnt_q <= 20'h0;
            active_q <= 1'b0;
        end
        else if (word_ok && rx_cmd != `RCWR_EOT_CODE)
        begin
            eot_cnt_q <= 20'h0;
            active_q <= 1'b1;
        end
        else if (eot_evt)
            active_q <= 1'b0;
        else if (tick && active_q)
            eot_cnt_q <= eot_cnt_q + 20'h1;
    end
    // Timeout gives way to a word landing on the same tick, else it is lost
    assign eot_evt = (word_ok && rx_cmd == `RCWR_EOT_CODE)
        || (tick && active_q && !word_ok
            && eot_cnt_q >= 20'(EOT_TICKS));

    // Latched command, subsystem flag and repeat blocking
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmd_out <= 6'h0;
            cmd_valid <= 1'b0;
            subsys_n <= 1'b1;
            sent_q <= 1'b0;
        end
        else
        begin
            cmd_valid <= word_ok;
            if (word_ok)
            begin
                cmd_out <= rx_cmd;
                if (rx_cmd >= `RCWR_SUB_LO && rx_cmd <= `RCWR_SUB_HI)
                    subsys_n <= 1'b0;
                else if (rx_cmd == `RCWR_SUB_OFF0
                         || rx_cmd == `RCWR_SUB_OFF1
                         || rx_cmd == `RCWR_SUB_OFF2)
                    subsys_n <= 1'b1;
            end
            if (eot_evt)
                sent_q <= 1'b0;
            else if (word_ok && !subsys_n)
                sent_q <= 1'b1;
        end
    end

    // Forward words unless blocked; end of transmission always goes out
    assign push_valid = eot_evt
        || (word_ok && !(sent_q && !subsys_n));
    assign push_word.eot = eot_evt;
    assign push_word.cmd = eot_evt ? `RCWR_EOT_CODE : rx_cmd;

    // ------------------------------------------------------------
    // Output FIFO and serialiser
    // ------------------------------------------------------------
    rcwr_pkg::rcwr_word_t pop_word;
    logic pop_valid;
    logic pop_ready;
    rcwr_pkg::rcwr_ser_state_t ser_q;
    logic [5:0] sh_q;
    logic [2:0] cnt_q;
    logic [3:0] sdiv_q;

    rcwr_fifo #(.WIDTH(7), .DEPTH(`RCWR_FIFO_DEPTH)) u_fifo (
        .clock(clock),
        .rst_n(rst_n),
        .in_data(push_word),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .out_data(pop_word),
        .out_valid(pop_valid),
        .out_ready(pop_ready)
    );
    assign pop_ready = (ser_q == rcwr_pkg::SER_IDLE);

    // Open-drain serial bus, bit order set by parameter
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ser_q <= rcwr_pkg::SER_IDLE;
            sh_q <= 6'h0;
            cnt_q <= 3'h0;
            sdiv_q <= 4'h0;
            ser_data_o <= 1'b0;
            ser_data_oe <= 1'b0;
            ser_clk_o <= 1'b0;
            ser_clk_oe <= 1'b0;
            ser_strobe_o <= 1'b0;
            ser_strobe_oe <= 1'b0;
        end
        else
        begin
            case (ser_q)
                rcwr_pkg::SER_IDLE:
                begin
                    ser_strobe_oe <= 1'b0;
                    if (pop_valid)
                    begin
                        sh_q <= pop_word.cmd;
                        cnt_q <= 3'h0;
                        sdiv_q <= 4'h0;
                        ser_q <= rcwr_pkg::SER_SHIFT;
                    end
                end
                rcwr_pkg::SER_SHIFT:
                begin
                    sdiv_q <= sdiv_q + 4'h1;
                    if (sdiv_q == 4'h0)
                    begin
                        // Bit 0 pulls the wire low
                        ser_data_oe <= SER_MSB_FIRST ? !sh_q[5] : !sh_q[0];
                        ser_clk_oe <= 1'b1;
                    end
                    else if (sdiv_q == 4'(`RCWR_SER_DIV / 2))
                        ser_clk_oe <= 1'b0;
                    else if (sdiv_q == 4'(`RCWR_SER_DIV - 1))
                    begin
                        sdiv_q <= 4'h0;
                        sh_q <= SER_MSB_FIRST ? {sh_q[4:0], 1'b0}
                                              : {1'b0, sh_q[5:1]};
                        cnt_q <= cnt_q + 3'h1;
                        if (cnt_q == 3'h5)
                            ser_q <= rcwr_pkg::SER_STROBE;
                    end
                end
                rcwr_pkg::SER_STROBE:
                begin
                    ser_data_oe <= 1'b0;
                    ser_strobe_oe <= 1'b1;
                    ser_q <= rcwr_pkg::SER_IDLE;
                end
                default:
                    ser_q <= rcwr_pkg::SER_IDLE;
            endcase
        end
    end
endmodule

// ### verification/rcwr_top_monitor.sv
// Checker on the ports of the remote command word receiver
`timescale 1ns/1ps
module rcwr_top_monitor #(
    parameter int REF_DIV = 4
)
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic pulse_in,
    input wire logic ser_data_o,
    input wire logic ser_data_oe,
    input wire logic ser_clk_o,
    input wire logic ser_clk_oe,
    input wire logic ser_strobe_o,
    input wire logic ser_strobe_oe,
    input wire logic subsys_n,
    input wire logic [5:0] cmd_out,
    input wire logic cmd_valid
);
    int bit_cnt;
    int idle_cnt;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);
    // ----------------------------------------
    // Helper counters
    // ----------------------------------------
    // Serial clock pulses since the last strobe
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            bit_cnt <= 0;
        else if (ser_strobe_oe)
            bit_cnt <= 0;
        else if ($rose(ser_clk_oe))
            bit_cnt <= bit_cnt + 1;
    end
    // Cycles since the last pulse edge, saturating
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            idle_cnt <= 1000;
        else if ($rose(pulse_in))
            idle_cnt <= 0;
        else if (idle_cnt < 1000)
            idle_cnt <= idle_cnt + 1;
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    chk_valid_pulse: assert property (cmd_valid |=> !cmd_valid)
        else $error("command valid longer than one cycle");
    chk_cmd_hold: assert property ($changed(cmd_out) |-> cmd_valid)
        else $error("command changed without a valid word");
    chk_valid_cause: assert property
        (cmd_valid |-> idle_cnt <= 8 * REF_DIV + 8)
        else $error("command valid without a recent stop pulse");
    chk_sub_enter: assert property ($fell(subsys_n) |->
        cmd_out >= 6'h38 && cmd_out <= 6'h3e)
        else $error("subsystem mode entered by a wrong command");
    chk_od_low: assert property
        (!(ser_data_o | ser_clk_o | ser_strobe_o))
        else $error("open drain output drives high");
    chk_clk_width: assert property
        ($rose(ser_clk_oe) |-> ser_clk_oe [*4] ##1 !ser_clk_oe)
        else $error("serial clock width wrong");
    chk_data_hold: assert property
        (ser_clk_oe && $past(ser_clk_oe) |-> $stable(ser_data_oe))
        else $error("serial data moved while clock active");
    chk_strobe_once: assert property
        ($rose(ser_strobe_oe) |=> !ser_strobe_oe)
        else $error("strobe longer than one cycle");
    chk_word_bits: assert property
        ($rose(ser_strobe_oe) |-> bit_cnt == 6 && !ser_clk_oe)
        else $error("serial word without six clock pulses");
    cover property (cmd_valid);
    cover property ($fell(subsys_n));
    cover property ($rose(ser_strobe_oe) && bit_cnt == 6);
endmodule
bind rcwr_top rcwr_top_monitor #(.REF_DIV(REF_DIV)) i_rcwr_top_monitor (
    .clock(clock), .resetn(resetn), .pulse_in(pulse_in),
    .ser_data_o(ser_data_o), .ser_data_oe(ser_data_oe),
    .ser_clk_o(ser_clk_o), .ser_clk_oe(ser_clk_oe),
    .ser_strobe_o(ser_strobe_o), .ser_strobe_oe(ser_strobe_oe),
    .subsys_n(subsys_n), .cmd_out(cmd_out), .cmd_valid(cmd_valid));

// ### verification/rcwr_tx_model.sv
// Transmitter model: pulse-distance coded words on the pulse line
`timescale 1ns/1ps
module rcwr_tx_model #(
    parameter int REF_DIV = 4
)
(
    input wire logic clock,
    input wire logic start,
    input wire logic [11:0] word,
    input wire logic [4:0] base,
    input wire logic [1:0] fault,
    output logic pulse_o,
    output logic busy
);
    // One pulse, then silence until gap ticks have passed
    task automatic pulse(input int gap);
        pulse_o = 1'b1;
        repeat (REF_DIV) @(negedge clock);
        pulse_o = 1'b0;
        repeat (gap * REF_DIV - REF_DIV) @(negedge clock);
    endtask
    // Start, reference, twelve bits, quiet interval, stop pulse
    initial
    begin
        int g;
        pulse_o = 1'b0;
        busy = 1'b0;
        forever
        begin
            @(negedge clock);
            if (start)
            begin
                busy = 1'b1;
                pulse(base);
                for (int i = 11; i >= 0; i--)
                begin
                    g = word[i] ? base * 3 / 2 : base;
                    if (fault == 2'd3 && i == 5)
                        g = base * 3;
                    if (fault == 2'd1 && i == 6)
                    begin
                        pulse(3);
                        g = g - 3;
                    end
                    pulse(g);
                end
                if (fault == 2'd2)
                    pulse(3);
                pulse(fault == 2'd2 ? base * 2 - 3 : base * 2);
                // Longer tail after a faulty word lets the receiver time out
                pulse(fault != 2'd0 ? 80 : 20);
                busy = 1'b0;
            end
        end
    end
endmodule

// ### verification/rcwr_test.sv
// Self-checking bench for the remote command word receiver
`timescale 1ns/1ps
module rcwr_test;
    localparam int REF_DIV = 4;
    localparam int EOT_TICKS = 400;
    logic clock, resetn, addr_sel, start, busy, pulse_in;
    logic ser_data_o, ser_data_oe, ser_clk_o, ser_clk_oe;
    logic ser_strobe_o, ser_strobe_oe, subsys_n, cmd_valid;
    logic [5:0] cmd_out;
    logic [11:0] word;
    logic [4:0] base;
    logic [1:0] fault;
    logic [5:0] sh = 6'h00;
    logic clk_q = 1'b0;
    logic stb_q = 1'b0;
    logic [5:0] exp_q[$], got_q[$], expc_q[$], gotc_q[$];
    logic [5:0] ex[3] = '{6'h02, 6'h0c, 6'h3f};
    logic sub_n, held, pend;
    int error_cnt = 0;
    int n_checks = 0;
    int cyc = 0;
    rcwr_top #(.EOT_TICKS(EOT_TICKS), .REF_DIV(REF_DIV)) i_rcwr_top (
        .clock(clock), .resetn(resetn), .pulse_in(pulse_in),
        .addr_sel(addr_sel), .ser_data_o(ser_data_o),
        .ser_data_oe(ser_data_oe), .ser_clk_o(ser_clk_o),
        .ser_clk_oe(ser_clk_oe), .ser_strobe_o(ser_strobe_o),
        .ser_strobe_oe(ser_strobe_oe), .subsys_n(subsys_n),
        .cmd_out(cmd_out), .cmd_valid(cmd_valid));
    rcwr_tx_model #(.REF_DIV(REF_DIV)) i_rcwr_tx_model (
        .clock(clock), .start(start), .word(word), .base(base),
        .fault(fault), .pulse_o(pulse_in), .busy(busy));
    // ----------------------------------------
    // Clock, timeout and collectors
    // ----------------------------------------
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // Serial bits in on clock pulses, words out on strobes, commands
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (cyc == 95000)
        begin
            error_cnt++;
            close_out();
        end
        if (ser_clk_oe && !clk_q)
            sh <= {sh[4:0], ~ser_data_oe};
        if (ser_strobe_oe && !stb_q)
            got_q.push_back(sh);
        if (cmd_valid === 1'b1 && cmd_out !== 6'h3f)
            gotc_q.push_back(cmd_out);
        clk_q <= ser_clk_oe;
        stb_q <= ser_strobe_oe;
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk6(input logic [5:0] got, input logic [5:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chkq(ref logic [5:0] g[$], ref logic [5:0] e[$]);
        chk6(6'(g.size()), 6'(e.size()));
        while (g.size() > 0 && e.size() > 0)
            chk6(g.pop_front(), e.pop_front());
        g.delete();
        e.delete();
    endtask
    task automatic wait_busy(input logic v);
        int n;
        n = 0;
        while (busy !== v && n < 5000)
        begin
            @(negedge clock);
            n++;
        end
        if (n == 5000)
            error_cnt++;
    endtask
    // Send one word and work out what the receiver must do with it
    task automatic send(input logic a, input logic [5:0] c,
                        input logic [1:0] f, input logic badp);
        logic ok;
        word = {a, 4'h0, ^c ^ badp, c};
        fault = f;
        base = 5'(10 + $urandom_range(2));
        ok = f == 2'd0 && !badp && a === addr_sel;
        start = 1'b1;
        wait_busy(1'b1);
        start = 1'b0;
        wait_busy(1'b0);
        if (ok && c == 6'h3f)
        begin
            exp_q.push_back(6'h3f);
            sub_n = 1'b1;
            held = 1'b0;
            pend = 1'b0;
        end
        else if (ok)
        begin
            expc_q.push_back(c);
            if (!held)
                exp_q.push_back(c);
            held = held | !sub_n;
            pend = 1'b1;
            if (c >= 6'h38 && c <= 6'h3e)
                sub_n = 1'b0;
            else if (c == 6'h02 || c == 6'h0c)
                sub_n = 1'b1;
        end
    endtask
    // Let the silence timer run out, then compare everything seen
    task automatic settle();
        repeat (EOT_TICKS * REF_DIV + 400) @(negedge clock);
        if (pend)
            exp_q.push_back(6'h3f);
        pend = 1'b0;
        held = 1'b0;
        chkq(got_q, exp_q);
        chkq(gotc_q, expc_q);
        chk1(subsys_n, sub_n);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        resetn = 1'b0;
        start = 1'b0;
        word = 12'h000;
        base = 5'h0a;
        fault = 2'd0;
        addr_sel = 1'b0;
        sub_n = 1'b1;
        held = 1'b0;
        pend = 1'b0;
        void'($urandom(32'h12bf));
        repeat (16) @(negedge clock);
        resetn = 1'b1;
        repeat (4) @(negedge clock);
        chk1(subsys_n, 1'b1);
        chk1(ser_data_oe | ser_clk_oe | ser_strobe_oe, 1'b0);
        $display("test reset done");
        for (int i = 0; i < 8; i++)
        begin
            logic a;
            addr_sel = 1'($urandom_range(1));
            a = 1'($urandom_range(1));
            send(a, 6'($urandom_range(55)), 2'd0, 1'b0);
            // A dropped word after a good one leaves the silence timer running
            if (pend && a !== addr_sel)
                settle();
        end
        settle();
        $display("test random done");
        addr_sel = 1'b1;
        for (int f = 1; f < 5; f++)
            send(1'b1, 6'h15, 2'(f), f == 4);
        send(1'b1, 6'h15, 2'd0, 1'b0);
        settle();
        $display("test faults done");
        for (int c = 56; c < 63; c++)
        begin
            send(1'b1, 6'(c), 2'd0, 1'b0);
            settle();
            send(1'b1, ex[c % 3], 2'd0, 1'b0);
            settle();
        end
        $display("test modes done");
        send(1'b1, 6'h3a, 2'd0, 1'b0);
        settle();
        repeat (3) send(1'b1, 6'h05, 2'd0, 1'b0);
        settle();
        send(1'b1, 6'h0c, 2'd0, 1'b0);
        settle();
        $display("test repeat done");
        close_out();
    end
endmodule
